/* core/mmd_consts.svh */
// Purpose: Offsets, field positions, reset values and codes of the decoder.
// Assumes: 16-bit byte addresses, 8-bit data.
// Notes: Included by the decoder.
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH
`define MMD_CTRL_ADDR 16'h0FD0
`define MMD_KEY_ADDR 16'h0FD1
`define MMD_READBACK_ADDR 16'h0FD2
`define MMD_CTRL_RESET 8'h40
`define MMD_COMMIT_CODE 8'hD5
`define MMD_BOOT_BIT 7
`define MMD_BOOT_LO 16'h1000
`define MMD_BOOT_HI 16'h17FF
`define MMD_FLASH_LO 16'h8000
`define MMD_FLASH_HI 16'hFFFF
`define MMD_SFR1_LO 16'h0000
`define MMD_SFR1_HI 16'h003F
`define MMD_SFR2_LO 16'h0F00
`define MMD_SFR2_HI 16'h0FFF
`define MMD_SFR3_LO 16'h0E40
`define MMD_SFR3_HI 16'h0EFF
`define MMD_RAM_LO 16'h0040
`define MMD_RAM_HI 16'h083F
`define MMD_UNMAPPED_DATA 8'hFF
`define MMD_SWI_OPCODE 8'hFF
`endif

/* core/mmd_pkg.sv */
// Purpose: Types shared by the memory map decoder.
// Assumes: Constants come from mmd_consts.svh.
// Notes: Holds the target selection enumeration.
package mmd_pkg;
   typedef enum logic [2:0] {
      MMD_TGT_NONE,
      MMD_TGT_FLASH,
      MMD_TGT_RAM,
      MMD_TGT_SFR,
      MMD_TGT_BOOT,
      MMD_TGT_MAPREG,
      MMD_TGT_FILL
   } mmd_target_t;
endpackage : mmd_pkg

/* core/mmd_decoder.sv */
// Purpose: Code and data area decoder with committed boot ROM mapping.
// Assumes: Bus signals come from the CPU on the same clock.
// Notes: The map control register is double buffered behind a key.
`timescale 1ns/1ps
`include "mmd_consts.svh"

module mmd_decoder import mmd_pkg::*; #(
   parameter bit FLASH_COVERS_BOOT = 1'b0
) (
   // Clock, reset and enable.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Instruction fetch side.
   input wire logic [15:0] fetch_addr,
   output mmd_target_t fetch_target,
   output logic fetch_use_swi,
   output logic [7:0] swi_opcode,
   // Data side.
   input wire logic [15:0] data_addr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [7:0] data_wdata,
   output mmd_target_t data_target,
   output logic [7:0] map_rdata,
   // Mode and status.
   input wire logic serial_prog_mode,
   output logic [7:0] committed_map_readback,
   output logic boot_rom_mapped
);
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] commit_reg;
   logic [7:0] commit_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic boot_map;
   logic fetch_in_boot;
   logic data_in_boot;
   logic fetch_in_flash;
   logic data_in_flash;
   logic data_in_sfr1;
   logic data_in_sfr2;
   logic data_in_sfr3;
   logic data_in_ram;

   // Holding register takes writes; committed copy only on the key.
   always_comb begin
      ctrl_next = ctrl_reg;
      commit_next = commit_reg;
      if (data_wr && data_addr == `MMD_CTRL_ADDR) begin
         ctrl_next = data_wdata;
      end
      if (data_wr && data_addr == `MMD_KEY_ADDR &&
          data_wdata == `MMD_COMMIT_CODE) begin
         commit_next = ctrl_reg;
      end
   end

   // Readback: key register is write-only and reads as zero.
   always_comb begin
      rdata_next = rdata_reg;
      if (data_rd) begin
         case (data_addr)
            `MMD_CTRL_ADDR: rdata_next = ctrl_reg;
            `MMD_READBACK_ADDR: rdata_next = commit_reg;
            `MMD_KEY_ADDR: rdata_next = 8'h00;
            default: rdata_next = `MMD_UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= `MMD_CTRL_RESET;
         commit_reg <= `MMD_CTRL_RESET;
         rdata_reg <= 8'h00;
      end else if (clk_en) begin
         ctrl_reg <= ctrl_next;
         commit_reg <= commit_next;
         rdata_reg <= rdata_next;
      end
   end

   assign boot_map = commit_reg[`MMD_BOOT_BIT];
   assign boot_rom_mapped = boot_map;
   assign committed_map_readback = commit_reg;
   assign map_rdata = rdata_reg;
   assign swi_opcode = `MMD_SWI_OPCODE;

   // The boot window spans exactly 2 Kbytes in every mode.
   mmd_window #(
      .LO(`MMD_BOOT_LO),
      .HI(`MMD_BOOT_HI)
   ) u_fetch_boot (
      .addr(fetch_addr),
      .hit(fetch_in_boot)
   );

   mmd_window #(
      .LO(`MMD_BOOT_LO),
      .HI(`MMD_BOOT_HI)
   ) u_data_boot (
      .addr(data_addr),
      .hit(data_in_boot)
   );

   mmd_window #(
      .LO(`MMD_FLASH_LO),
      .HI(`MMD_FLASH_HI)
   ) u_fetch_flash (
      .addr(fetch_addr),
      .hit(fetch_in_flash)
   );

   mmd_window #(
      .LO(`MMD_FLASH_LO),
      .HI(`MMD_FLASH_HI)
   ) u_data_flash (
      .addr(data_addr),
      .hit(data_in_flash)
   );

   mmd_window #(
      .LO(`MMD_SFR1_LO),
      .HI(`MMD_SFR1_HI)
   ) u_data_sfr1 (
      .addr(data_addr),
      .hit(data_in_sfr1)
   );

   mmd_window #(
      .LO(`MMD_SFR2_LO),
      .HI(`MMD_SFR2_HI)
   ) u_data_sfr2 (
      .addr(data_addr),
      .hit(data_in_sfr2)
   );

   mmd_window #(
      .LO(`MMD_SFR3_LO),
      .HI(`MMD_SFR3_HI)
   ) u_data_sfr3 (
      .addr(data_addr),
      .hit(data_in_sfr3)
   );

   mmd_window #(
      .LO(`MMD_RAM_LO),
      .HI(`MMD_RAM_HI)
   ) u_data_ram (
      .addr(data_addr),
      .hit(data_in_ram)
   );

   // Code area decode.
   always_comb begin
      fetch_target = MMD_TGT_NONE;
      fetch_use_swi = 1'b0;
      if (fetch_in_flash) begin
         fetch_target = MMD_TGT_FLASH;
      end else if (fetch_in_boot) begin
         if (boot_map || serial_prog_mode) begin
            fetch_target = MMD_TGT_BOOT;
         end else if (FLASH_COVERS_BOOT) begin
            fetch_target = MMD_TGT_FLASH;
         end else begin
            fetch_use_swi = 1'b1;
         end
      end
   end

   // Data area decode; SFR windows carry reserved holes software avoids.
   always_comb begin
      data_target = MMD_TGT_NONE;
      if (data_in_flash) begin
         data_target = MMD_TGT_FLASH;
      end else if (data_addr == `MMD_CTRL_ADDR ||
                   data_addr == `MMD_KEY_ADDR ||
                   data_addr == `MMD_READBACK_ADDR) begin
         data_target = MMD_TGT_MAPREG;
      end else if (data_in_sfr1 || data_in_sfr2 || data_in_sfr3) begin
         data_target = MMD_TGT_SFR;
      end else if (data_in_ram) begin
         data_target = MMD_TGT_RAM;
      end else if (data_in_boot) begin
         if (boot_map || serial_prog_mode) begin
            data_target = MMD_TGT_BOOT;
         end else begin
            data_target = MMD_TGT_FILL;
         end
      end
   end
endmodule : mmd_decoder

// Flags an address that falls inside one inclusive window.
module mmd_window #(
   parameter logic [15:0] LO = 16'h0000,
   parameter logic [15:0] HI = 16'hFFFF
) (
   // Address in.
   input wire logic [15:0] addr,
   // Window hit.
   output logic hit
);
   assign hit = addr >= LO && addr <= HI;
endmodule : mmd_window

/* tb/mmd_decoder_properties.sv */
// Purpose: Decode checks.
// Assumes: FLASH_COVERS_BOOT is 0.
// Notes: Bound below.
`timescale 1ns/1ps
module mmd_decoder_properties import mmd_pkg::*; (
   // Watched ports.
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] fetch_addr,
   input wire mmd_target_t fetch_target,
   input wire logic [15:0] data_addr,
   input wire logic data_wr,
   input wire logic [7:0] data_wdata,
   input wire mmd_target_t data_target,
   input wire logic serial_prog_mode,
   input wire logic [7:0] committed_map_readback,
   input wire logic boot_rom_mapped
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire bw = data_addr inside {[16'h1000:16'h17FF]};
   sequence s_key; data_wr && data_addr == 16'h0FD1; endsequence
   a_boot_data: assert property (boot_rom_mapped && bw |->
      data_target == MMD_TGT_BOOT) else $error("boot");
   a_fill_read: assert property (!boot_rom_mapped && !serial_prog_mode
      && bw |-> data_target == MMD_TGT_FILL) else $error("fill");
   a_key_refuse: assert property (s_key ##0 data_wdata != 8'hD5
      |=> $stable(committed_map_readback)) else $error("key");
   a_ctrl_hold: assert property (data_wr && data_addr == 16'h0FD0
      |=> $stable(committed_map_readback)) else $error("hold");
   a_flash_data: assert property (data_addr[15] |->
      data_target == MMD_TGT_FLASH) else $error("flash data");
   a_flash_code: assert property (fetch_addr[15] |->
      fetch_target == MMD_TGT_FLASH) else $error("flash");
   a_ram_data: assert property (data_addr inside {[16'h0040:16'h083F]}
      |-> data_target == MMD_TGT_RAM) else $error("ram");
   a_sfr_data: assert property (data_addr <= 16'h003F |->
      data_target == MMD_TGT_SFR) else $error("sfr");
   a_reset_map: assert property ($fell(sys_rst) |->
      committed_map_readback == 8'h40) else $error("reset");
endmodule : mmd_decoder_properties
bind mmd_decoder mmd_decoder_properties u_chk (.*);

/* tb/mmd_cpu_model.sv */
// Purpose: CPU data bus master.
// Assumes: One-cycle strobes.
// Notes: Released data is inverted.
`timescale 1ns/1ps
module mmd_cpu_model (
   // Bus.
   input wire logic clk,
   output logic [15:0] data_addr = 0,
   output logic data_wr = 0,
   output logic data_rd = 0,
   output logic [7:0] data_wdata = 0
);
   task automatic cyc(input logic w, input logic r,
      input logic [15:0] a, input logic [7:0] d);
      @(posedge clk) #1 {data_addr, data_wr, data_rd, data_wdata} = {a, w, r, d};
      @(posedge clk) #1 {data_wr, data_rd, data_wdata} = {2'b00, ~d};
   endtask : cyc
endmodule : mmd_cpu_model

/* tb/mmd_decoder_tb.sv */
// Purpose: Decoder bench.
// Assumes: clk_en tied high.
// Notes: comm models the committed byte.
`timescale 1ns/1ps
module mmd_decoder_tb import mmd_pkg::*;;
   logic clk = 0, sys_rst = 1, serial_prog_mode = 0, data_wr, data_rd;
   logic fetch_use_swi;
   logic [15:0] fetch_addr = 0, data_addr;
   logic [7:0] data_wdata, map_rdata, committed_map_readback;
   mmd_target_t fetch_target, data_target;
   int error_cnt = 0, n_tests = 0, cyc = 0, comm = 'h40, a;
   initial forever #25 clk = ~clk;
   mmd_cpu_model CPU (.*);
   mmd_decoder DUT (.clk_en(1'b1), .swi_opcode(),
      .boot_rom_mapped(), .*);
   task automatic chk(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %h %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] tgt(input int a);
      if (a[15]) return MMD_TGT_FLASH;
      if (a inside {['hFD0:'hFD2]}) return MMD_TGT_MAPREG;
      if (a < 'h40 || a inside {['hE40:'hEFF], ['hF00:'hFFF]})
         return MMD_TGT_SFR;
      if (a < 'h840) return MMD_TGT_RAM;
      if (a inside {['h1000:'h17FF]})
         return comm[7] | serial_prog_mode ? MMD_TGT_BOOT : MMD_TGT_FILL;
      return MMD_TGT_NONE;
   endfunction : tgt
   function automatic logic [7:0] ftgt(input int a);
      if (a[15]) return MMD_TGT_FLASH;
      if (a inside {['h1000:'h17FF]} && (comm[7] || serial_prog_mode))
         return MMD_TGT_BOOT;
      return MMD_TGT_NONE;
   endfunction : ftgt
   task automatic probe(input int n);
      repeat (n) begin
         a = $urandom & 'h9FFF;
         fetch_addr = a[15:0];
         CPU.cyc(0, 0, a[15:0], 0);
         chk(data_target, tgt(a));
         chk(fetch_target, ftgt(a));
         chk(fetch_use_swi, a inside {['h1000:'h17FF]} &&
            ftgt(a) == MMD_TGT_NONE);
         chk(committed_map_readback, comm);
      end
   endtask : probe
   task automatic summarize;
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   always @(posedge clk) if (++cyc > 3000) begin
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(46677));
      repeat (3) @(posedge clk);
      #1 sys_rst = 0;
      probe(30);
      CPU.cyc(1, 0, 'hFD0, 'h80);
      probe(20);
      CPU.cyc(1, 0, 'hFD1, 8'($urandom % 'hD5));
      probe(20);
      CPU.cyc(1, 0, 'hFD1, 'hD5);
      comm = 'h80;
      probe(30);
      CPU.cyc(0, 1, 'hFD2, 0);
      chk(map_rdata, comm);
      CPU.cyc(0, 1, 'hFD1, 0);
      chk(map_rdata, 8'h00);
      serial_prog_mode = 1;
      CPU.cyc(1, 0, 'hFD0, 'h40);
      CPU.cyc(1, 0, 'hFD1, 'hD5);
      comm = 'h40;
      probe(30);
      serial_prog_mode = 0;
      probe(30);
      summarize();
   end
endmodule : mmd_decoder_tb
